/* verilog/sar_ctl_pkg.sv */
// Constants and carrier types of the converter control block.
// Assumes a 200 MHz clk_i; every nanosecond figure below is turned into a count of its cycles.
// Notes on behaviour
// R1 - convert-start rise with select low samples
// R2 - select fall with convert-start high samples
// R3 - back-to-back: sample at internal conversion end
// R4 - falling edge ends sampling, starts conversion
// R5 - busy high through conversion, low after
// R6 - select fall during busy aborts, code FE0
// R7 - data driven only when select, read low
// R8 - narrow read puts D3..D0 then zeros up
// R9 - host uses back-to-back above 3.5 MSPS
// R10 - new sampling allowed before busy falls
// R11 - host avoids accidental abort edges
// R12 - nap after busy falls while nap low
// R13 - host lengthens acquisition after nap
// R14 - nap only while low, idle, not sampling
// R15 - nap pin may change at any time
// R16 - reset phase shows code FE0
// R17 - long reset low enters powerdown
// R18 - first four results after reset invalid
// R19 - internal clock, conversion within 200 ns
// R20 - reset aborts conversion, release resumes
// R21 - straight binary result coding
// R22 - result held until next conversion ends
package sar_ctl_pkg;
   localparam int          CLK_MHZ        = 200;
   localparam int          CONV_TIME_NS   = 200;
   localparam int          CONV_CYC       = (CONV_TIME_NS * CLK_MHZ) / 1000;
   localparam int          ABORT_NS       = 45;
   localparam int          ABORT_CYC      = (ABORT_NS * CLK_MHZ) / 1000;
   localparam int          RST_PHASE_NS   = 100;
   localparam int          RST_PHASE_CYC  = (RST_PHASE_NS * CLK_MHZ) / 1000;
   localparam int          PWD_THRESH_NS  = 1000;
   localparam int          PWD_THRESH_CYC = (PWD_THRESH_NS * CLK_MHZ) / 1000;
   localparam int          WARMUP_CONVS   = 4;
   localparam logic [11:0] CODE_ABORT     = 12'hFE0;
   localparam logic [11:0] CODE_RESET     = 12'h000;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_SAMPLE = 5'h02,
      ST_CONV   = 5'h04,
      ST_NAP    = 5'h08,
      ST_RESET  = 5'h10
   } phase_t;

   // Pins of the host-side control group, after synchronising
   typedef struct packed {
      logic cs_n;
      logic convert_start_n;
      logic rd_n;
      logic byte_sel;
      logic nap_enable_n;
      logic powerdown_reset_n;
   } ctl_pins_t;
endpackage

/* verilog/sar_ctl_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are unrelated to clk_i; output is 2 cycles late.
module sar_ctl_sync #(
   parameter int W = 6
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Pins
   input  wire logic [W-1:0] pins_i,
   output logic      [W-1:0] pins_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.meta = pins_i;
      s_d.sync = s_q.meta;
   end

   // Idle-high pins reset to inactive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{meta: '1, sync: '1};
      end else begin
         s_q <= s_d;
      end
   end

   assign pins_o = s_q.sync;
endmodule

/* verilog/sar_ctl.sv */
// Control and readout of a 12-bit successive-approximation converter.
// Assumes the analog core hands a finished code on sar_code_i; all host
// pins are asynchronous and pass the two-flop synchroniser first.
// Every pin event therefore lands three clk_i edges after the pin moves:
// two for the synchroniser and one for the phase register.
// Limitation: pin edges closer than one cycle apart may merge, so a
// host must space its edges by at least that much.
module sar_ctl #(
   parameter int RST_PHASE_CYC  = sar_ctl_pkg::RST_PHASE_CYC,
   parameter int PWD_THRESH_CYC = sar_ctl_pkg::PWD_THRESH_CYC,
   parameter int CONV_CYC       = sar_ctl_pkg::CONV_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Host control pins
   input  wire logic        cs_n_i,
   input  wire logic        convert_start_n_i,
   input  wire logic        rd_n_i,
   input  wire logic        byte_sel_i,
   input  wire logic        nap_enable_n_i,
   input  wire logic        powerdown_reset_n_i,
   // Analog core
   input  wire logic [11:0] sar_code_i,
   output logic             sample_o,
   output logic             nap_o,
   output logic             powerdown_o,
   output logic             warmup_o,
   // Status and data pins
   output logic             busy_o,
   output logic [11:0]      data_o,
   output logic [11:0]      data_oe_o
);
   // Raw pins gathered into one word so the synchroniser sees a group
   sar_ctl_pkg::ctl_pins_t pin_raw;
   // Same group, two edges later and safe to decode
   sar_ctl_pkg::ctl_pins_t pin;

   assign pin_raw = '{cs_n:              cs_n_i,
                      convert_start_n:   convert_start_n_i,
                      rd_n:              rd_n_i,
                      byte_sel:          byte_sel_i,
                      nap_enable_n:      nap_enable_n_i,
                      powerdown_reset_n: powerdown_reset_n_i};

   // All six pins share one synchroniser instance
   sar_ctl_sync #(
      .W($bits(sar_ctl_pkg::ctl_pins_t))
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pins_i(pin_raw),
      .pins_o(pin)
   );

   // Whole state of the block in one word. The previous pin levels are
   // kept so that edges are found against the synchronised copies only.
   typedef struct packed {
      // Operating phase
      sar_ctl_pkg::phase_t phase;
      // Pin levels of the previous edge, for edge detection
      logic                cs_n;
      logic                cvs_n;
      // Conversion cycle counter
      logic [15:0]         cnt;
      // Cycles that the powerdown/reset pin has been held low
      logic [15:0]         rst_cnt;
      // Conversions still to run before results are trusted
      logic [2:0]          warm;
      logic                pwd;
      // Last completed, aborted or reset code
      logic [11:0]         result;
      // Registered output side
      logic                byte_sel;
      logic [11:0]         dout;
      logic                oe;
   } ctl_state_t;

   ctl_state_t s_q;
   ctl_state_t s_d;

   // Previous levels reset to the idle high level of both pins, so the
   // release of rst_i looks like a falling edge only on a pin held low
   logic cs_fall;
   logic cvs_rise;
   logic cvs_fall;

   assign cs_fall  = s_q.cs_n & ~pin.cs_n;
   assign cvs_rise = ~s_q.cvs_n & pin.convert_start_n;
   assign cvs_fall = s_q.cvs_n & ~pin.convert_start_n;

   // Sampling opens on a convert-start rise with select low, or on a
   // select fall with convert-start high
   function automatic logic opens_sample(input logic cs_fall_e,
                                         input logic cvs_rise_e,
                                         input logic cs_n,
                                         input logic cvs_n);
      opens_sample = (cvs_rise_e & ~cs_n) | (cs_fall_e & cvs_n);
   endfunction

   // Sampling closes, and a conversion starts, on a falling edge of
   // either pin while the other one is already low
   function automatic logic closes_sample(input logic cs_fall_e,
                                          input logic cvs_fall_e,
                                          input logic cs_n,
                                          input logic cvs_n);
      closes_sample = (cvs_fall_e & ~cs_n) | (cs_fall_e & ~cvs_n);
   endfunction

   // Narrow reads put the low nibble on the top pins, zeros beneath
   function automatic logic [11:0] fold(input logic [11:0] w,
                                        input logic        narrow);
      fold = narrow ? {w[3:0], 8'h00} : w; // R8
   endfunction

   // Next-state logic: every field starts from its current value
   always_comb begin
      s_d       = s_q;
      s_d.cs_n  = pin.cs_n;
      s_d.cvs_n = pin.convert_start_n;
      // The powerdown/reset pin outranks every other pin: while it is low
      // no edge of select or convert-start is acted on.
      if (!pin.powerdown_reset_n) begin
         // Reset aborts at once, well inside the abort bound
         s_d.phase  = sar_ctl_pkg::ST_RESET; // R20
         s_d.result = sar_ctl_pkg::CODE_ABORT; // R16
         s_d.warm   = 3'(sar_ctl_pkg::WARMUP_CONVS);
         // Powerdown is never declared inside the reset phase, even if the
         // threshold is set shorter than the phase
         if (s_q.rst_cnt < 16'(PWD_THRESH_CYC) ||
             s_q.rst_cnt < 16'(RST_PHASE_CYC)) begin
            s_d.rst_cnt = s_q.rst_cnt + 16'h0001;
         end else begin
            s_d.pwd = 1'b1; // R17
         end
      end else begin
         s_d.rst_cnt = 16'h0000;
         s_d.pwd     = 1'b0;
         case (s_q.phase)
            sar_ctl_pkg::ST_RESET: begin
               s_d.phase = sar_ctl_pkg::ST_IDLE; // R20
            end
            sar_ctl_pkg::ST_IDLE, sar_ctl_pkg::ST_NAP: begin
               if (opens_sample(cs_fall, cvs_rise, pin.cs_n,
                                pin.convert_start_n)) begin
                  s_d.phase = sar_ctl_pkg::ST_SAMPLE; // R1 R2
               end else if (closes_sample(cs_fall, cvs_fall, pin.cs_n,
                                          pin.convert_start_n)) begin
                  s_d.phase = sar_ctl_pkg::ST_CONV; // R4
                  s_d.cnt   = 16'h0000;
               end else if (!pin.nap_enable_n) begin
                  s_d.phase = sar_ctl_pkg::ST_NAP; // R12 R14 R15
               end else begin
                  s_d.phase = sar_ctl_pkg::ST_IDLE; // R14
               end
            end
            sar_ctl_pkg::ST_SAMPLE: begin
               if (closes_sample(cs_fall, cvs_fall, pin.cs_n,
                                 pin.convert_start_n)) begin
                  s_d.phase = sar_ctl_pkg::ST_CONV; // R4
                  s_d.cnt   = 16'h0000;
               end
            end
            sar_ctl_pkg::ST_CONV: begin
               // Convert-start is high here, so the abort leaves the block
               // sampling again
               if (cs_fall && pin.convert_start_n) begin
                  s_d.result = sar_ctl_pkg::CODE_ABORT; // R6
                  s_d.phase  = sar_ctl_pkg::ST_SAMPLE;
               end else if (s_q.cnt >= 16'(CONV_CYC - 1)) begin
                  s_d.result = sar_code_i; // R19 R21 R22
                  // Count down the conversions whose results are not valid
                  if (s_q.warm != 3'h0) begin
                     s_d.warm = s_q.warm - 3'h1; // R18
                  end
                  // Back-to-back: sampling opens at the internal end
                  if (!pin.cs_n && pin.convert_start_n) begin
                     s_d.phase = sar_ctl_pkg::ST_SAMPLE; // R3 R10
                  end else if (!pin.nap_enable_n) begin
                     s_d.phase = sar_ctl_pkg::ST_NAP; // R12
                  end else begin
                     s_d.phase = sar_ctl_pkg::ST_IDLE; // R5
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 16'h0001;
               end
            end
            default: s_d.phase = sar_ctl_pkg::ST_IDLE;
         endcase
      end
      // Output side follows the pins every cycle; the word is taken from
      // the next result so a finished code is readable one edge sooner.
      // Trade-off: data and enable lag the pins by three edges.
      s_d.byte_sel = pin.byte_sel;
      s_d.dout     = fold(s_d.result, pin.byte_sel);
      s_d.oe       = ~pin.cs_n & ~pin.rd_n; // R7
   end

   // One register holds the whole state; rst_i is synchronous
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Pins read as idle high after rst_i, matching their idle level
         s_q <= '{phase:    sar_ctl_pkg::ST_RESET,
                  cs_n:     1'b1,
                  cvs_n:    1'b1,
                  cnt:      16'h0000,
                  rst_cnt:  16'h0000,
                  warm:     3'(sar_ctl_pkg::WARMUP_CONVS),
                  pwd:      1'b0,
                  result:   sar_ctl_pkg::CODE_RESET,
                  byte_sel: 1'b0,
                  dout:     12'h000,
                  oe:       1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Busy, sample and nap pins compare the whole one-hot phase word with one state;
   // each is a five-bit compare after the phase register, not a single bit.
   assign busy_o      = (s_q.phase == sar_ctl_pkg::ST_CONV); // R5
   assign sample_o    = (s_q.phase == sar_ctl_pkg::ST_SAMPLE);
   assign nap_o       = (s_q.phase == sar_ctl_pkg::ST_NAP);
   assign powerdown_o = s_q.pwd;
   assign warmup_o    = (s_q.warm != 3'h0);
   assign data_o      = s_q.dout;
   assign data_oe_o   = {12{s_q.oe}};
endmodule

/* bench/sar_ctl_checker.sv */
// Timing checks on the pins of the converter control block.
// Pins are asynchronous and the block answers them 3 cycles late.
module sar_ctl_checker #(
   parameter int CONV_CYC = 40
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Host pins
   input wire logic        cs_n_i,
   input wire logic        convert_start_n_i,
   input wire logic        rd_n_i,
   input wire logic        byte_sel_i,
   input wire logic        powerdown_reset_n_i,
   // Block outputs
   input wire logic        busy_o,
   input wire logic        sample_o,
   input wire logic        nap_o,
   input wire logic        powerdown_o,
   input wire logic [11:0] data_o,
   input wire logic [11:0] data_oe_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int busy_q;
   always_ff @(posedge clk_i) busy_q <= (rst_i || !busy_o) ? 0 : busy_q + 1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_busy_bound: assert property (busy_q <= CONV_CYC)
      else $error("busy longer than a conversion");
   chk_start_busy: assert property ($fell(convert_start_n_i) && !cs_n_i
      && sample_o |-> ##[2:5] busy_o)
      else $error("conversion did not start");
   chk_abort_end: assert property ($fell(cs_n_i) && busy_o
      && convert_start_n_i |-> ##[1:5] !busy_o)
      else $error("abort did not end busy");
   chk_oe_read: assert property (|data_oe_o |-> !$past(cs_n_i, 3)
      && !$past(rd_n_i, 3))
      else $error("bus driven without a read");
   chk_narrow_zero: assert property (data_oe_o[0] && $past(byte_sel_i, 3)
      && $past(byte_sel_i, 4) |-> data_o[7:0] == 8'h00)
      else $error("narrow read low byte not zero");
   chk_nap_idle: assert property (nap_o |-> !busy_o && !sample_o)
      else $error("nap while active");
   chk_reset_busy: assert property (!powerdown_reset_n_i [*5] |-> !busy_o)
      else $error("busy kept during reset");
   chk_pwd_level: assert property (powerdown_o |-> !$past(powerdown_reset_n_i,
      5) && !$past(powerdown_reset_n_i, 20))
      else $error("powerdown without long reset");
endmodule
bind sar_ctl sar_ctl_checker #(.CONV_CYC(CONV_CYC)) chk_i (
   .clk_i              (clk_i),
   .rst_i              (rst_i),
   .cs_n_i             (cs_n_i),
   .convert_start_n_i  (convert_start_n_i),
   .rd_n_i             (rd_n_i),
   .byte_sel_i         (byte_sel_i),
   .powerdown_reset_n_i(powerdown_reset_n_i),
   .busy_o             (busy_o),
   .sample_o           (sample_o),
   .nap_o              (nap_o),
   .powerdown_o        (powerdown_o),
   .data_o             (data_o),
   .data_oe_o          (data_oe_o)
);

/* bench/sar_host.sv */
// Host side: drives the control pins and the core's code.
// Pins change just after a rising edge of clk_i, as a host would.
module sar_host (
   // Clock and status
   input  wire logic        clk_i,
   input  wire logic        busy_i,
   // Control pins and core code
   output logic             cs_n_o,
   output logic             cst_n_o,
   output logic             rd_n_o,
   output logic             byte_sel_o,
   output logic             nap_n_o,
   output logic             pwd_n_o,
   output logic [11:0]      code_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {cs_n_o, cst_n_o, rd_n_o, byte_sel_o, nap_n_o, pwd_n_o} = 6'h3B;
   initial code_o = 12'h000;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Select stays low so a running conversion never sees a stray abort
   task automatic conv(input logic [11:0] c, input int acq, input bit b2b);
      code_o <= c;
      cs_n_o <= 1'b0;
      cst_n_o <= 1'b1;
      tick(acq);
      cst_n_o <= 1'b0;
      tick(4);
      if (b2b) cst_n_o <= 1'b1;
      for (int k = 0; k < 60 && busy_i; k++) tick(1);
   endtask
   task automatic rd(input logic nb, input logic rdn);
      cs_n_o <= 1'b0;
      byte_sel_o <= nb;
      rd_n_o <= rdn;
      tick(4);
   endtask
endmodule

/* bench/sar_ctl_tb.sv */
// Self-checking bench of the converter control block.
// Pins come from sar_host; a queue holds the codes expected.
module sar_ctl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i, rst_i, cs_n_i, convert_start_n_i, rd_n_i;
   logic        byte_sel_i, nap_enable_n_i, powerdown_reset_n_i;
   logic        sample_o, nap_o, powerdown_o, warmup_o, busy_o;
   logic [11:0] sar_code_i, data_o, data_oe_o;
   logic [11:0] corner [3] = '{12'h000, 12'h800, 12'hFFF};
   logic [31:0] seed = 32'h8052;
   logic [11:0] exp_q [$];
   int          fails, samples_checked;
   sar_ctl #(
      .RST_PHASE_CYC (20),
      .PWD_THRESH_CYC(40)
   ) sar_ctl_i (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .cs_n_i             (cs_n_i),
      .convert_start_n_i  (convert_start_n_i),
      .rd_n_i             (rd_n_i),
      .byte_sel_i         (byte_sel_i),
      .nap_enable_n_i     (nap_enable_n_i),
      .powerdown_reset_n_i(powerdown_reset_n_i),
      .sar_code_i         (sar_code_i),
      .sample_o           (sample_o),
      .nap_o              (nap_o),
      .powerdown_o        (powerdown_o),
      .warmup_o           (warmup_o),
      .busy_o             (busy_o),
      .data_o             (data_o),
      .data_oe_o          (data_oe_o)
   );
   sar_host sar_host_i (.clk_i(clk_i), .busy_i(busy_o), .cs_n_o(cs_n_i),
      .cst_n_o(convert_start_n_i), .rd_n_o(rd_n_i), .byte_sel_o(byte_sel_i),
      .nap_n_o(nap_enable_n_i), .pwd_n_o(powerdown_reset_n_i),
      .code_o(sar_code_i));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   function automatic logic [11:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[11:0];
   endfunction
   task automatic check(input logic [11:0] got, input logic [11:0] want);
      samples_checked++;
      if (got !== want) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic readout();
      logic [11:0] v;
      v = exp_q[$];
      sar_host_i.rd(1'b0, 1'b0);
      check(data_o, v);
      check(data_oe_o, 12'hFFF);
      sar_host_i.rd(1'b1, 1'b0);
      check(data_o, {v[3:0], 8'h00});
      sar_host_i.rd(1'b0, 1'b1);
      check(data_oe_o, 12'h000);
   endtask
   task automatic conv(input logic [11:0] c, input int acq, input bit b2b);
      exp_q.push_back(c);
      sar_host_i.conv(c, acq, b2b);
      check({11'h000, busy_o}, 12'h000);
      if (b2b) check({11'h000, sample_o}, 12'h001);
      readout();
   endtask
   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      sar_host_i.tick(4000);
      fails++;
      give_verdict();
   end
   initial begin
      rst_i = 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      sar_host_i.tick(3);
      exp_q.push_back(12'h000);
      readout();
      foreach (corner[i]) conv(corner[i], 6, 1'b0);
      for (int i = 0; i < 8; i++) conv(rnd(), 6, i[0]);
      sar_host_i.cst_n_o <= 1'b0;
      sar_host_i.tick(6);
      sar_host_i.cst_n_o <= 1'b1;
      sar_host_i.cs_n_o <= 1'b1;
      sar_host_i.tick(3);
      sar_host_i.cs_n_o <= 1'b0;
      sar_host_i.tick(5);
      check({11'h000, busy_o}, 12'h000);
      check({11'h000, sample_o}, 12'h001);
      exp_q.push_back(12'hFE0);
      readout();
      sar_host_i.nap_n_o <= 1'b0;
      conv(rnd(), 6, 1'b0);
      check({11'h000, nap_o}, 12'h001);
      sar_host_i.nap_n_o <= 1'b1;
      sar_host_i.tick(4);
      check({11'h000, nap_o}, 12'h000);
      sar_host_i.nap_n_o <= 1'b0;
      sar_host_i.tick(4);
      check({11'h000, nap_o}, 12'h001);
      conv(rnd(), 18, 1'b0);
      sar_host_i.nap_n_o <= 1'b1;
      sar_host_i.cst_n_o <= 1'b1;
      sar_host_i.tick(6);
      sar_host_i.cst_n_o <= 1'b0;
      sar_host_i.tick(6);
      sar_host_i.pwd_n_o <= 1'b0;
      sar_host_i.tick(6);
      check({11'h000, busy_o}, 12'h000);
      check({11'h000, powerdown_o}, 12'h000);
      exp_q.push_back(12'hFE0);
      readout();
      sar_host_i.tick(30);
      check({11'h000, powerdown_o}, 12'h001);
      sar_host_i.pwd_n_o <= 1'b1;
      sar_host_i.tick(4);
      check({10'h000, powerdown_o, warmup_o}, 12'h001);
      for (int i = 0; i < 4; i++) conv(rnd(), 6, 1'b0);
      check({11'h000, warmup_o}, 12'h000);
      give_verdict();
   end
endmodule
